// file: rtl/psm_pkg.sv
package psm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CLK_DIV_ADDR  = 4'h4;
  localparam logic [3:0] STATUS_ADDR   = 4'h8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OSC_SWITCH_BIT = 0;
  localparam int OSC_NEXT_LSB   = 8;
  localparam int OSC_CUR_LSB    = 12;
  localparam int DIV_CPU_SLOWDOWN_ENABLE_BIT  = 11;
  localparam int DIV_RATIO_LSB  = 12;
  localparam int DIV_ROI_BIT    = 15;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [2:0] SRC_RESET    = 3'h0;
  localparam logic [2:0] RATIO_RESET  = 3'h0;
  localparam logic [2:0] WAKE_CYCLES  = 3'h3;
  localparam logic       OP_SLEEP     = 1'b0;
  localparam logic       OP_IDLE      = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_ENTER = 3'b001,
    ST_SLEEP = 3'b010,
    ST_IDLE  = 3'b011,
    ST_WAKE  = 3'b100
  } psm_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } psm_bus_s;

endpackage

// file: rtl/psm_power_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Unlocked software selects next oscillator source
// - Sleep operand stops clocks, halts code
// - Idle operand halts CPU, peripherals run
// - Interrupt, watchdog timeout or reset wakes
// - Sleep shuts down system clock source
// - Fail-safe monitor stopped during sleep
// - Sleep keeps RC clock when watchdog enabled
// - Watchdog count cleared on entering sleep when watchdog enabled
// - Sleep disables system-clocked peripherals
// - Wake from sleep uses same source
// - Entering idle clears watchdog count
// - Idle keeps system clock and peripherals
// - Idle keeps RC clock for watchdog/monitor
// - Idle wake resumes CPU 2-4 cycles later
// - Interrupt during entry held, then wakes
// - Doze slows only CPU, peripherals full speed
// - Doze enable bit 11 enters doze
// - Ratio field bits 14:12, reset 1:1
// - Restore-on-interrupt bit ends doze on interrupt
module psm_power_ctrl
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire psm_pkg::psm_bus_s bus,
  output logic [15:0]            rd_data,
  input  wire logic              power_save_instruction,
  input  wire logic              save_operand,
  input  wire logic              irq_pending,
  input  wire logic              wdt_timeout,
  input  wire logic              wdt_enabled,
  input  wire logic              fail_safe_clock_monitor_enabled,
  input  wire logic              clk_cfg_locked,
  output logic                   cpu_clk_en,
  output logic                   periph_clk_en,
  output logic                   sys_osc_en,
  output logic                   low_power_rc_clock_en,
  output logic                   fail_safe_clock_monitor_active,
  output logic                   wdt_clear,
  output logic                   cpu_resume,
  output logic [2:0]             active_source
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  psm_pkg::psm_state_e state_ff;
  psm_pkg::psm_state_e nxt_state;
  logic [2:0]          next_src_ff;
  logic [2:0]          active_src_ff;
  logic [2:0]          saved_src_ff;
  logic                sleep_op_ff;
  logic                irq_hold_ff;
  logic                cpu_slowdown_enable_ff;
  logic [2:0]          ratio_ff;
  logic                roi_ff;
  logic [6:0]          doze_cnt_ff;
  logic [2:0]          wake_cnt_ff;
  logic [15:0]         rd_data_ff;
  logic                wdt_clear_ff;
  logic                wake_event;
  logic                in_sleep;
  logic                in_idle;
  logic                doze_tick;
  logic                wr_osc;
  logic                wr_div;

  // Address match shared by writes and reads
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // Divisor mask for a power-of-two ratio
  function automatic logic [6:0] ratio_mask(input logic [2:0] r);
    ratio_mask = 7'((8'h01 << r) - 8'h01);
  endfunction

  assign wr_osc     = bus.wr && hit(bus.addr, psm_pkg::OSC_CTRL_ADDR);
  assign wr_div     = bus.wr && hit(bus.addr, psm_pkg::CLK_DIV_ADDR);
  assign in_sleep   = (state_ff == psm_pkg::ST_SLEEP);
  assign in_idle    = (state_ff == psm_pkg::ST_IDLE);
  assign wake_event = irq_pending || wdt_timeout || irq_hold_ff;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  // Next mode
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      psm_pkg::ST_RUN:
      begin
        if (power_save_instruction)
          nxt_state = psm_pkg::ST_ENTER;
      end
      psm_pkg::ST_ENTER:
      begin
        if (sleep_op_ff)
          nxt_state = psm_pkg::ST_SLEEP;
        else
          nxt_state = psm_pkg::ST_IDLE;
      end
      psm_pkg::ST_SLEEP:
      begin
        if (wake_event)
          nxt_state = psm_pkg::ST_RUN;
      end
      psm_pkg::ST_IDLE:
      begin
        if (wake_event)
          nxt_state = psm_pkg::ST_WAKE;
      end
      psm_pkg::ST_WAKE:
      begin
        if (wake_cnt_ff == 3'h1)
          nxt_state = psm_pkg::ST_RUN;
      end
      default: nxt_state = psm_pkg::ST_RUN;
    endcase
  end

  // Mode register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_ff <= psm_pkg::ST_RUN;
    else
      state_ff <= nxt_state;
  end

  // Operand capture at instruction
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sleep_op_ff <= 1'b0;
    else if (state_ff == psm_pkg::ST_RUN && power_save_instruction)
      sleep_op_ff <= (save_operand == psm_pkg::OP_SLEEP);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_hold_ff <= 1'b0;
    else if (state_ff == psm_pkg::ST_ENTER && irq_pending)
      irq_hold_ff <= 1'b1;
    else if (in_sleep || in_idle)
      irq_hold_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wake_cnt_ff <= 3'h0;
    else if (in_idle && wake_event)
      wake_cnt_ff <= psm_pkg::WAKE_CYCLES;
    else if (wake_cnt_ff != 3'h0)
      wake_cnt_ff <= wake_cnt_ff - 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wdt_clear_ff <= 1'b0;
    else
      wdt_clear_ff <= (state_ff == psm_pkg::ST_ENTER) && (sleep_op_ff ? wdt_enabled : 1'b1);
  end

  // ----------------------------------------
  // Oscillator selection
  // ----------------------------------------
  // next source write when unlocked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      next_src_ff <= psm_pkg::SRC_RESET;
    else if (wr_osc && !clk_cfg_locked)
      next_src_ff <= bus.wdata[psm_pkg::OSC_NEXT_LSB +: 3];
  end

  // Source switch request and wake restore
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      active_src_ff <= psm_pkg::SRC_RESET;
    else if (in_sleep && wake_event)
      active_src_ff <= saved_src_ff;
    else if (wr_osc && !clk_cfg_locked && bus.wdata[psm_pkg::OSC_SWITCH_BIT])
      active_src_ff <= bus.wdata[psm_pkg::OSC_NEXT_LSB +: 3];
  end

  // Source saved at sleep entry
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      saved_src_ff <= psm_pkg::SRC_RESET;
    else if (state_ff == psm_pkg::ST_ENTER)
      saved_src_ff <= active_src_ff;
  end

  // ----------------------------------------
  // Doze control
  // ----------------------------------------
  // divider register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cpu_slowdown_enable_ff <= 1'b0;
      ratio_ff <= psm_pkg::RATIO_RESET;
      roi_ff   <= 1'b0;
    end
    else if (wr_div)
    begin
      cpu_slowdown_enable_ff <= bus.wdata[psm_pkg::DIV_CPU_SLOWDOWN_ENABLE_BIT];
      ratio_ff <= bus.wdata[psm_pkg::DIV_RATIO_LSB +: 3];
      roi_ff   <= bus.wdata[psm_pkg::DIV_ROI_BIT];
    end
    else if (roi_ff && irq_pending)
      cpu_slowdown_enable_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      doze_cnt_ff <= 7'h00;
    else if (!cpu_slowdown_enable_ff || doze_cnt_ff >= ratio_mask(ratio_ff))
      doze_cnt_ff <= 7'h00;
    else
      doze_cnt_ff <= doze_cnt_ff + 7'h01;
  end

  // tick keeps CPU aligned to system clock
  assign doze_tick = !cpu_slowdown_enable_ff || (doze_cnt_ff == ratio_mask(ratio_ff));

  // ----------------------------------------
  // Clock gating outputs
  // ----------------------------------------
  // CPU runs only in run mode
  assign cpu_clk_en            = (state_ff == psm_pkg::ST_RUN) && doze_tick;
  assign periph_clk_en         = !in_sleep;
  assign sys_osc_en            = !in_sleep;
  assign low_power_rc_clock_en = in_sleep ? wdt_enabled : (wdt_enabled || fail_safe_clock_monitor_enabled);
  assign fail_safe_clock_monitor_active           = fail_safe_clock_monitor_enabled && !in_sleep;
  assign wdt_clear             = wdt_clear_ff;
  assign cpu_resume            = (state_ff == psm_pkg::ST_WAKE) && (wake_cnt_ff == 3'h1);
  assign active_source         = active_src_ff;

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Read data one cycle after strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_data_ff <= 16'h0000;
    else if (bus.rd && hit(bus.addr, psm_pkg::OSC_CTRL_ADDR))
      rd_data_ff <= {1'b0, active_src_ff, 1'b0, next_src_ff, 8'h00};
    else if (bus.rd && hit(bus.addr, psm_pkg::CLK_DIV_ADDR))
      rd_data_ff <= {roi_ff, ratio_ff, cpu_slowdown_enable_ff, 11'h000};
    else if (bus.rd && hit(bus.addr, psm_pkg::STATUS_ADDR))
      rd_data_ff <= {13'h0000, state_ff};
    else
      rd_data_ff <= 16'h0000;
  end

  assign rd_data = rd_data_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_locked_src_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
      (wr_osc && clk_cfg_locked) |=> $stable(next_src_ff))
    else $error("next source changed while locked");

  chk_sleep_entry:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == psm_pkg::ST_ENTER && sleep_op_ff) |=> in_sleep && !cpu_clk_en)
    else $error("sleep not entered");

  chk_idle_periph:
    assert property (@(posedge clk) disable iff (!rst_n)
      in_idle |-> periph_clk_en && sys_osc_en && !cpu_clk_en)
    else $error("idle gating wrong");

  chk_sleep_wake:
    assert property (@(posedge clk) disable iff (!rst_n)
      (in_sleep && wdt_timeout) |=> state_ff == psm_pkg::ST_RUN)
    else $error("no wake from sleep");

  chk_sleep_osc:
    assert property (@(posedge clk) disable iff (!rst_n)
      in_sleep |-> !sys_osc_en && !periph_clk_en && !fail_safe_clock_monitor_active)
    else $error("clock alive in sleep");

  chk_rc_keep:
    assert property (@(posedge clk) disable iff (!rst_n)
      (in_sleep && wdt_enabled) |-> low_power_rc_clock_en)
    else $error("rc clock off in sleep");

  chk_wdt_clear:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == psm_pkg::ST_ENTER && !sleep_op_ff) |=> wdt_clear)
    else $error("watchdog not cleared on idle");

  chk_src_restore:
    assert property (@(posedge clk) disable iff (!rst_n)
      (in_sleep && wake_event) |=> active_src_ff == $past(saved_src_ff))
    else $error("source not restored");

  chk_idle_resume:
    assert property (@(posedge clk) disable iff (!rst_n)
      (in_idle && wake_event) |=> !cpu_clk_en [*3] ##1 state_ff == psm_pkg::ST_RUN)
    else $error("idle wake delay wrong");

  chk_entry_irq:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == psm_pkg::ST_ENTER && irq_pending) |=> ##1 !in_sleep && !in_idle)
    else $error("entry interrupt lost");

  chk_doze_rate:
    assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_slowdown_enable_ff && ratio_ff == 3'h2 && state_ff == psm_pkg::ST_RUN && cpu_clk_en
       && !wr_div && !irq_pending)
      |=> !cpu_clk_en)
    else $error("doze ratio wrong");

  chk_roi_exit:
    assert property (@(posedge clk) disable iff (!rst_n)
      (roi_ff && irq_pending && !wr_div) |=> !cpu_slowdown_enable_ff)
    else $error("doze kept on interrupt");

  chk_fail_safe_clock_monitor_awake:
    assert property (@(posedge clk) disable iff (!rst_n)
      (fail_safe_clock_monitor_enabled && !in_sleep) |-> fail_safe_clock_monitor_active)
    else $error("monitor off outside sleep");

  chk_wdt_sleep:
    assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == psm_pkg::ST_ENTER && sleep_op_ff && wdt_enabled) |=> wdt_clear)
    else $error("watchdog not cleared on sleep");

  chk_rc_idle:
    assert property (@(posedge clk) disable iff (!rst_n)
      (in_idle && (wdt_enabled || fail_safe_clock_monitor_enabled)) |-> low_power_rc_clock_en)
    else $error("rc clock off in idle");

  chk_doze_periph:
    assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_slowdown_enable_ff && state_ff == psm_pkg::ST_RUN) |-> periph_clk_en && sys_osc_en)
    else $error("peripherals slowed in doze");

  chk_doze_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      (!cpu_slowdown_enable_ff && state_ff == psm_pkg::ST_RUN) |-> cpu_clk_en)
    else $error("cpu slowed without doze");

  chk_resume_run:
    assert property (@(posedge clk) disable iff (!rst_n)
      cpu_resume |=> state_ff == psm_pkg::ST_RUN)
    else $error("resume without run");

endmodule

// file: testbench/psm_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) \
    begin \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); \
      mismatches++; \
    end \
  end

module testbench;
  logic              clk;
  logic              rst_n;
  psm_pkg::psm_bus_s bus;
  logic [15:0]       rd_data;
  logic              psi, sop, irq, wto, wen, fen, lck;
  logic              cpu_en, per_en, osc_en, rc_en, fs_act, wclr, resume;
  logic [2:0]        act_src;
  logic [2:0]        src;
  logic [15:0]       rv;
  logic              seen;
  int                mismatches, compares, cycles, cnt, n;

  // ----------------------------------------
  // Clock, timeout, design
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cut a hung run short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  psm_power_ctrl dut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .power_save_instruction(psi), .save_operand(sop), .irq_pending(irq),
    .wdt_timeout(wto), .wdt_enabled(wen), .fail_safe_clock_monitor_enabled(fen), .clk_cfg_locked(lck),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .sys_osc_en(osc_en),
    .low_power_rc_clock_en(rc_en), .fail_safe_clock_monitor_active(fs_act), .wdt_clear(wclr),
    .cpu_resume(resume), .active_source(act_src)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // RC clock need in a low-power state
  function automatic logic rc_exp(logic o, logic w, logic f);
    return o ? (w | f) : w;
  endfunction

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rv = rd_data;
  endtask

  // Issue power-save, land in ENTER
  task automatic ps(logic o, logic w, logic f);
    @(posedge clk);
    psi <= 1'b1;
    sop <= o;
    wen <= w;
    fen <= f;
    @(posedge clk);
    psi <= 1'b0;
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    {psi, sop, irq, wto, wen, fen, lck} = '0;
    void'($urandom(53));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state
    rd(psm_pkg::CLK_DIV_ADDR);
    `CHK("div reset", 16'h0000, rv)
    #1 `CHK("cpu en reset", 1'b1, cpu_en)
    // Doze ratios, peripherals at full speed
    for (int r = 0; r < 8; r++)
    begin
      wr(psm_pkg::CLK_DIV_ADDR, 16'h0800 | (16'(r) << 12));
      repeat (2) @(posedge clk);
      cnt = 0;
      n = 0;
      repeat (128)
      begin
        @(posedge clk);
        #1 cnt += int'(cpu_en === 1'b1);
        n += int'(per_en !== 1'b1);
      end
      `CHK("doze highs", 128 >> r, cnt)
      `CHK("periph stalls", 0, n)
    end
    // Interrupt with and without restore
    for (int k = 0; k < 2; k++)
    begin
      wr(psm_pkg::CLK_DIV_ADDR, 16'h2800 | (k ? 16'h8000 : 16'h0000));
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rd(psm_pkg::CLK_DIV_ADDR);
      `CHK("roi div", k ? 16'hA000 : 16'h2800, rv)
    end
    wr(psm_pkg::CLK_DIV_ADDR, 16'h0000);
    // Source select under lock, then switch
    src = 3'($urandom_range(7, 1));
    lck <= 1'b1;
    wr(psm_pkg::OSC_CTRL_ADDR, 16'(src) << 8);
    rd(psm_pkg::OSC_CTRL_ADDR);
    `CHK("locked osc", 16'h0000, rv)
    @(posedge clk);
    lck <= 1'b0;
    wr(psm_pkg::OSC_CTRL_ADDR, (16'(src) << 8) | 16'h0001);
    rd(psm_pkg::OSC_CTRL_ADDR);
    `CHK("osc switch", (16'(src) << 12) | (16'(src) << 8), rv)
    wr(psm_pkg::STATUS_ADDR, 16'hFFFF);
    rd(psm_pkg::STATUS_ADDR);
    `CHK("status ro", 16'h0000, rv)
    rd(4'hC);
    `CHK("unmapped", 16'h0000, rv)
    // Sleep and idle entry and wake
    for (int t = 0; t < 8; t++)
    begin
      ps(t[0], 1'($urandom), 1'($urandom));
      @(posedge clk);
      #1 `CHK("state", t[0] ? 3'h3 : 3'h2, dut.state_ff)
      `CHK("cpu halt", 1'b0, cpu_en)
      `CHK("periph", t[0], per_en)
      `CHK("sys osc", t[0], osc_en)
      `CHK("fail_safe_clock_monitor", t[0] & fen, fs_act)
      `CHK("rc clk", rc_exp(t[0], wen, fen), rc_en)
      `CHK("wdt clr", t[0] | wen, wclr)
      @(posedge clk);
      if (t[1]) wto <= 1'b1;
      else irq <= 1'b1;
      n = 0;
      seen = 1'b0;
      while (n < 8 && cpu_en !== 1'b1)
      begin
        @(posedge clk);
        #1 n++;
        seen |= (resume === 1'b1);
      end
      if (t[0]) `CHK("idle wake", 1'b1, (n >= 2 && n <= 4) && seen)
      else `CHK("sleep wake", 1, n)
      `CHK("same src", src, act_src)
      @(posedge clk);
      wto <= 1'b0;
      irq <= 1'b0;
    end
    // Interrupt during entry is held
    ps(1'b0, 1'b1, 1'b0);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    #1 `CHK("held sleep", 1'b0, osc_en)
    @(posedge clk);
    #1 `CHK("held wake", 1'b1, osc_en)
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
